// file: common/fpd_pkg.sv
// Purpose: Types shared by the front panel decoder
// Assumes: Nothing beyond the constants header
// Notes: Carrier structs for module outputs and status inputs
package fpd_pkg;

   // Timing stages behind a display group write (one-hot)
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ONE = 3'b010,
      ST_TWO = 3'b100
   } fpd_stage_e;

   // Serial lines to the first synthesizer
   typedef struct packed {
      logic serialStrobe;
      logic serialClock;
      logic serialData;
   } fpd_synth1_s;

   // Second synthesizer settings
   typedef struct packed {
      logic beatOscEnable;
      logic [6:0] freqSetting;
   } fpd_synth2_s;

   // Status and encoder inputs gated by the status read
   typedef struct packed {
      logic encoderB;
      logic encoderA;
      logic meterSwitch;
      logic cmpIsbRf;
      logic cmpMainRf;
      logic cmpAf;
      logic scanInhibit;
   } fpd_status_s;

   typedef logic [6:0] fpd_seg_t;

endpackage

// file: common/fpd_regs.svh
// Purpose: Port numbers, field positions and reset values of the front panel decoder
// Assumes: Six port-select lines, active-high write and read strobes
// Notes: Definitions only
`ifndef FPD_REGS_SVH
`define FPD_REGS_SVH

// ************************************************
// Write ports (full six-bit port number)
// ************************************************
`define FPD_WP_RXBUS 6'h30
`define FPD_WP_SYNTH1A 6'h31
`define FPD_WP_GROUP_LO 6'h32
`define FPD_WP_GROUP_HI 6'h37
`define FPD_WP_SYNTH2 6'h38
`define FPD_WP_SYNTH1B 6'h39
`define FPD_WP_IFAF_LO 6'h3a
`define FPD_WP_COUNTER 6'h20
`define FPD_WP_MEMORY 6'h03

// ************************************************
// Read selector outputs (port number with bit 5 set)
// ************************************************
`define FPD_RD_ENABLE_BIT 5
`define FPD_RD_COL_A 3'h0
`define FPD_RD_MEMORY 3'h1
`define FPD_RD_COL_B 3'h2
`define FPD_RD_COL_C 3'h3
`define FPD_RD_COL_D 3'h4
`define FPD_RD_STATUS 3'h5

// ************************************************
// Field positions and reset values
// ************************************************
`define FPD_S1_DATA_BIT 0
`define FPD_S1_CLOCK_BIT 1
`define FPD_S1_STROBE_BIT 0
`define FPD_BFO_EN_BIT 7
`define FPD_RST_BYTE 8'h00
`define FPD_RST_FREQ 7'h00
`define FPD_RST_COUNT 4'h0
`define FPD_RST_BCD 4'hf

`endif

// file: dv/fpd_chk.sv
// Purpose: Port checks for the front panel decoder
// Assumes: One clock, sync active-high reset
// Notes: Bound into every decoder instance
`timescale 1ns/1ps
module fpd_chk
   import fpd_pkg::*;
#(
   parameter int DIGITS = 16,
   parameter int MEM_AW = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Port bus
   input wire logic [5:0] portSelectLines,
   input wire logic portWritePulse,
   input wire logic portReadStrobe,
   input wire logic [7:0] portDataIn,
   input wire logic [7:0] portDataOut,
   input wire logic portDataOe,
   // Panel side
   input wire logic [3:0] switchColumns,
   input wire logic [7:0] switchRows,
   input wire fpd_status_s statusIn,
   input wire logic [7:0] receiverSideBus,
   input wire logic [3:0] digitSelect,
   input wire logic [5:0] displayGroupStrobes,
   input wire logic [DIGITS-1:0] digitStrobes,
   input wire fpd_seg_t [DIGITS-1:0] segments,
   // Module outputs
   input wire fpd_synth1_s synth1,
   input wire fpd_synth2_s synth2,
   input wire logic [7:0] ifAfData,
   input wire logic [5:0] ifAfStrobes
);
   // ****
   // Request decode
   // ****
   logic rd;
   logic wr;
   logic [5:0] sel;
   assign rd = portReadStrobe && portSelectLines[5];
   assign wr = portWritePulse;
   assign sel = portSelectLines;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   // ****
   // Assertions
   // ****
   oe_follow_a: assert property (rd |=> portDataOe)
      else $error("no read enable");
   col_onehot_a: assert property ($onehot0(switchColumns))
      else $error("columns overlap");
   col_pick_a: assert property (rd && sel[2:0] == 3'h0 |=> switchColumns == 4'h1)
      else $error("wrong column");
   rows_read_a: assert property (rd ##1 rd && $stable(sel) && sel[2:0] == 3'h0
      |=> portDataOut == $past(switchRows))
      else $error("rows not read");
   status_read_a: assert property (rd && sel[2:0] == 3'h5
      |=> portDataOut == {1'b0, $past(statusIn)})
      else $error("status not read");
   rx_latch_a: assert property (wr && sel == 6'h30
      |=> receiverSideBus == $past(portDataIn))
      else $error("bus not latched");
   group_pulse_a: assert property (wr && sel >= 6'h32 && sel <= 6'h37 &&
      displayGroupStrobes == 6'h00 && $past(displayGroupStrobes) == 6'h00
      |=> displayGroupStrobes == 6'(6'h01 << ($past(sel) - 6'h32)))
      else $error("group strobe wrong");
   digit_strobe_a: assert property (displayGroupStrobes != 6'h00
      && $past(displayGroupStrobes) == 6'h00 && $past(displayGroupStrobes, 2) == 6'h00
      |-> ##2 digitStrobes == 16'h1 << $past(digitSelect, 2))
      else $error("digit strobe wrong");
   count_step_a: assert property (digitStrobes != '0 && !$past(wr && sel == 6'h20)
      |-> digitSelect == 4'($past(digitSelect) + 4'h1))
      else $error("counter not stepped");
   synth1_a: assert property (wr && sel == 6'h31
      |=> synth1.serialClock == $past(portDataIn[1]) && synth1.serialData == $past(portDataIn[0]))
      else $error("synth1 lines wrong");
   synth2_a: assert property (wr && sel == 6'h38 |=> synth2 == $past(portDataIn))
      else $error("synth2 not loaded");
   ifaf_a: assert property (wr && sel >= 6'h3a |=> ifAfData == $past(portDataIn) &&
      ifAfStrobes == 6'(6'h01 << ($past(sel) - 6'h3a)))
      else $error("if af strobe wrong");
   // Main scenarios reached
   cover property (rd ##1 rd);
   cover property (displayGroupStrobes != 6'h00 ##2 digitStrobes != '0);
   cover property (wr && sel == 6'h03);
endmodule

bind fpd_strobe_decoder fpd_chk #(.DIGITS(DIGITS), .MEM_AW(MEM_AW)) chk (.*);

// file: dv/fpd_panel_model.sv
// Purpose: Front panel stand-in, switch matrix and tuning encoder
// Assumes: At most one column driven
// Notes: Encoder steps when the bench asks
`timescale 1ns/1ps
module fpd_panel_model (
   // Clock
   input wire logic clk,
   // Switch matrix
   input wire logic [3:0] switchColumns,
   output logic [7:0] switchRows,
   // Encoder control and outputs
   input wire logic stepEn,
   input wire logic stepCw,
   output logic encA,
   output logic encB
);
   logic [1:0] phase_q = 2'h0;
   initial switchRows = 8'h5a;
   // Rows of the driven column, else a changing pattern
   always @(switchColumns) begin
      if (switchColumns != 4'h0) begin
         switchRows = {switchColumns, ~switchColumns};
      end else begin
         switchRows = ~switchRows;
      end
   end
   // Quarter steps of the shaft
   always @(posedge clk) begin
      if (stepEn) begin
         phase_q <= stepCw ? phase_q + 2'h1 : phase_q - 2'h1;
      end
   end
   // First output leads when clockwise
   assign encA = (phase_q == 2'h1) || (phase_q == 2'h2);
   assign encB = phase_q[1];
endmodule

// file: dv/front_panel_io_strobe_decoder_tb_top.sv
// Purpose: Self-checking bench of the front panel decoder
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Port numbers as in the constants header
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module front_panel_io_strobe_decoder_tb_top
   import fpd_pkg::*;
;
   // ****
   // Signals, parts and tasks
   // ****
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] sel = 6'h00;
   logic wrP = 1'b0;
   logic rdS = 1'b0;
   logic stepEn = 1'b0;
   logic stepCw = 1'b1;
   logic [7:0] din = 8'h00;
   logic [4:0] stat = 5'h15;
   logic [7:0] dout, rows, rxBus, ifAfData, got;
   logic oe, encA, encB;
   logic [3:0] cols, digSel, colSeen;
   logic [5:0] grp, ifAfS, grpSeen, ifSeen;
   logic [15:0] digS;
   fpd_seg_t [15:0] seg;
   fpd_synth1_s s1;
   fpd_synth2_s s2;
   logic [2:0] colSel [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
   logic [1:0] encExp [5] = '{2'b01, 2'b11, 2'b10, 2'b00, 2'b10};
   logic [7:0] memD [2] = '{8'h3c, 8'hc3};
   int fail_count = 0;
   int cmp_count = 0;
   always #25 clk = ~clk;
   fpd_strobe_decoder #(.DIGITS(16), .MEM_AW(10)) uut (.clk(clk), .rst(rst),
      .portSelectLines(sel), .portWritePulse(wrP), .portReadStrobe(rdS),
      .portDataIn(din), .portDataOut(dout), .portDataOe(oe), .switchColumns(cols),
      .switchRows(rows), .statusIn({encB, encA, stat}), .receiverSideBus(rxBus),
      .digitSelect(digSel), .displayGroupStrobes(grp), .digitStrobes(digS),
      .segments(seg), .synth1(s1), .synth2(s2), .ifAfData(ifAfData), .ifAfStrobes(ifAfS));
   fpd_panel_model panel (.clk(clk), .switchColumns(cols), .switchRows(rows),
      .stepEn(stepEn), .stepCw(stepCw), .encA(encA), .encB(encB));
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // One write; pulses caught in the cycle they stand
   task automatic wr(logic [5:0] p, logic [7:0] d);
      sel = p;
      din = d;
      wrP = 1'b1;
      tick(1);
      wrP = 1'b0;
      grpSeen = grp;
      ifSeen = ifAfS;
      tick(1);
   endtask
   // Two-cycle read, column caught while driven
   task automatic rd(logic [5:0] p, output logic [7:0] d);
      sel = p;
      rdS = 1'b1;
      tick(2);
      d = dout;
      colSeen = cols;
      `CHK(oe, 1'b1);
      rdS = 1'b0;
      tick(1);
      `CHK(oe, 1'b0);
      `CHK(dout, 8'h00);
   endtask
   task automatic print_verdict();
      $display("Compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ****
   // Tests
   // ****
   initial begin
      tick(8);
      `CHK(s2, 8'h00);
      `CHK(seg[0], 7'h00);
      rst = 1'b0;
      tick(1);
      // Each column alone, its rows read back
      foreach (colSel[k]) begin
         rd({3'b100, colSel[k]}, got);
         `CHK(colSeen, 4'h1 << k);
         `CHK(got, {4'h1 << k, ~(4'h1 << k)});
      end
      // Four clockwise quarter steps, then one back
      foreach (encExp[k]) begin
         stepCw = (k < 4);
         stepEn = 1'b1;
         stat = ~stat;
         tick(1);
         stepEn = 1'b0;
         rd(6'h25, got);
         `CHK(got, {1'b0, encExp[k], stat});
      end
      rd(6'h26, got);
      `CHK(got, 8'h00);
      // Display groups, counter wrap, digit latches
      wr(6'h30, 8'h05);
      `CHK(rxBus, 8'h05);
      wr(6'h20, 8'h0f);
      for (int k = 0; k < 6; k++) begin
         wr(6'h32 + 6'(k), 8'h00);
         `CHK(grpSeen, 6'h01 << k);
         tick(1);
         `CHK(digS, 16'h1 << 4'(15 + k));
         `CHK(digSel, 4'(k));
      end
      tick(2);
      `CHK(seg[15], 7'h6d);
      `CHK(seg[5], 7'h00);
      wr(6'h32, 8'h00);
      wr(6'h33, 8'h00);
      `CHK(grpSeen, 6'h02);
      tick(2);
      `CHK(digSel, 4'h6);
      // Synthesizer lines, IF/AF data and strobes
      wr(6'h31, 8'h03);
      `CHK(s1, 3'b011);
      wr(6'h39, 8'h01);
      `CHK(s1, 3'b111);
      wr(6'h38, 8'ha5);
      `CHK(s2, 8'ha5);
      for (int k = 0; k < 6; k++) begin
         wr(6'h3a + 6'(k), 8'h10 + 8'(k));
         `CHK(ifSeen, 6'h01 << k);
         `CHK(ifAfData, 8'h10 + 8'(k));
      end
      // Channel memory, addresses differ in counter bits
      wr(6'h30, 8'h2a);
      foreach (memD[k]) begin
         wr(6'h20, 8'(k));
         wr(6'h03, memD[k]);
      end
      foreach (memD[k]) begin
         wr(6'h20, 8'(k));
         rd(6'h21, got);
         `CHK(got, memD[k]);
      end
      print_verdict();
   end
   // Cut a hang short
   initial begin
      #100us;
      fail_count++;
      print_verdict();
   end
endmodule

// file: logic/fpd_strobe_decoder.sv
// Purpose: Front panel I/O strobe decoder, switch scan, display, synth strobes, channel memory
// Assumes: All inputs synchronous to clk; port select held during the data cycle
// Notes: Read data is registered; hold the read strobe two cycles for valid data
`timescale 1ns/1ps
`include "fpd_regs.svh"

module fpd_strobe_decoder
   import fpd_pkg::*;
#(
   parameter int DIGITS = 16,
   parameter int MEM_AW = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Processor port bus
   input wire logic [5:0] portSelectLines,
   input wire logic portWritePulse,
   input wire logic portReadStrobe,
   input wire logic [7:0] portDataIn,
   output logic [7:0] portDataOut,
   output logic portDataOe,
   // Switch matrix
   output logic [3:0] switchColumns,
   input wire logic [7:0] switchRows,
   // Status and encoder inputs
   input wire fpd_status_s statusIn,
   // Receiver-side bus and display strobes
   output logic [7:0] receiverSideBus,
   output logic [3:0] digitSelect,
   output logic [5:0] displayGroupStrobes,
   output logic [DIGITS-1:0] digitStrobes,
   output fpd_seg_t [DIGITS-1:0] segments,
   // Synthesizers and IF/AF
   output fpd_synth1_s synth1,
   output fpd_synth2_s synth2,
   output logic [7:0] ifAfData,
   output logic [5:0] ifAfStrobes
);

   // ************************************************
   // Elaboration checks
   // ************************************************
   if (DIGITS != 16) begin : gDigitsCheck
      $error("DIGITS must be 16 for a four-bit digit counter");
   end
   if (MEM_AW != 10) begin : gMemCheck
      $error("MEM_AW must be 10: six bus bits plus four counter bits");
   end

   // ************************************************
   // Port decode
   // ************************************************
   logic wr;
   logic rd;
   logic [2:0] rdSel;
   logic [3:0] colReq;
   logic groupWr;
   fpd_stage_e stage_q;
   logic [2:0] groupIdx_q;
   logic [3:0] count_q;
   logic [7:0] rxBus_q;
   logic [MEM_AW-1:0] memAddr;
   logic [3:0] memLo [0:(1<<MEM_AW)-1];
   logic [3:0] memHi [0:(1<<MEM_AW)-1];
   logic [3:0] bcd_q [0:DIGITS-1];

   // Write and read selector qualifiers
   assign wr = portWritePulse;
   assign rd = portReadStrobe && portSelectLines[`FPD_RD_ENABLE_BIT];
   assign rdSel = portSelectLines[2:0];
   assign groupWr = wr && (portSelectLines >= `FPD_WP_GROUP_LO)
      && (portSelectLines <= `FPD_WP_GROUP_HI);

   // Column selector, one-hot
   always_comb begin
      colReq = 4'h0;
      if (rd) begin
         case (rdSel)
            `FPD_RD_COL_A: colReq = 4'h1;
            `FPD_RD_COL_B: colReq = 4'h2;
            `FPD_RD_COL_C: colReq = 4'h4;
            `FPD_RD_COL_D: colReq = 4'h8;
            default: colReq = 4'h0;
         endcase
      end
   end

   // ************************************************
   // Switch scan and read data path
   // ************************************************
   // Column drive register
   always_ff @(posedge clk) begin
      if (rst) begin
         switchColumns <= 4'h0;
      end else begin
         switchColumns <= colReq;
      end
   end

   // Read data mux, registered
   always_ff @(posedge clk) begin
      if (rst) begin
         portDataOut <= `FPD_RST_BYTE;
         portDataOe <= 1'b0;
      end else begin
         portDataOe <= rd;
         if (!rd) begin
            portDataOut <= `FPD_RST_BYTE;
         end else if (rdSel == `FPD_RD_STATUS) begin
            portDataOut <= {1'b0, statusIn};
         end else if (rdSel == `FPD_RD_MEMORY) begin
            portDataOut <= {memHi[memAddr], memLo[memAddr]};
         end else if (switchColumns != 4'h0 && switchColumns == colReq) begin
            portDataOut <= switchRows;
         end else begin
            portDataOut <= `FPD_RST_BYTE;
         end
      end
   end

   // ************************************************
   // Receiver-side bus latch
   // ************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         rxBus_q <= `FPD_RST_BYTE;
      end else if (wr && portSelectLines == `FPD_WP_RXBUS) begin
         rxBus_q <= portDataIn;
      end
   end
   assign receiverSideBus = rxBus_q;

   // ************************************************
   // Display strobe timing and digit counter
   // ************************************************
   // Two timing stages after a group write
   always_ff @(posedge clk) begin
      if (rst) begin
         stage_q <= ST_IDLE;
         groupIdx_q <= 3'h0;
      end else begin
         case (stage_q)
            ST_IDLE: begin
               if (groupWr) begin
                  stage_q <= ST_ONE;
                  groupIdx_q <= portSelectLines[2:0];
               end
            end
            ST_ONE: stage_q <= ST_TWO;
            ST_TWO: stage_q <= ST_IDLE;
            default: stage_q <= ST_IDLE;
         endcase
      end
   end

   // Digit counter: loaded by its port, else advanced with each strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= `FPD_RST_COUNT;
      end else if (wr && portSelectLines == `FPD_WP_COUNTER) begin
         count_q <= portDataIn[3:0];
      end else if (stage_q == ST_TWO) begin
         count_q <= count_q + 4'h1;
      end
   end
   assign digitSelect = count_q;

   // Group strobes pulse one cycle after the write
   always_ff @(posedge clk) begin
      if (rst) begin
         displayGroupStrobes <= 6'h00;
      end else begin
         displayGroupStrobes <= 6'h00;
         if (groupWr) begin
            displayGroupStrobes[portSelectLines[2:0] - 3'h2] <= 1'b1;
         end
      end
   end

   // One-of-sixteen digit latch strobe, registered from the second stage so it pulses in the following cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         digitStrobes <= '0;
      end else begin
         digitStrobes <= '0;
         if (stage_q == ST_TWO) begin
            digitStrobes[count_q] <= 1'b1;
         end
      end
   end

   // ************************************************
   // Digit latches and segment decode
   // ************************************************
   for (genvar i = 0; i < DIGITS; i++) begin : gDigit
      always_ff @(posedge clk) begin
         if (rst) begin
            bcd_q[i] <= `FPD_RST_BCD;
         end else if (digitStrobes[i]) begin
            bcd_q[i] <= rxBus_q[3:0];
         end
      end
      // Segment register, blank for non-decimal codes
      always_ff @(posedge clk) begin
         if (rst) begin
            segments[i] <= 7'h00;
         end else begin
            case (bcd_q[i])
               4'h0: segments[i] <= 7'h3f;
               4'h1: segments[i] <= 7'h06;
               4'h2: segments[i] <= 7'h5b;
               4'h3: segments[i] <= 7'h4f;
               4'h4: segments[i] <= 7'h66;
               4'h5: segments[i] <= 7'h6d;
               4'h6: segments[i] <= 7'h7d;
               4'h7: segments[i] <= 7'h07;
               4'h8: segments[i] <= 7'h7f;
               4'h9: segments[i] <= 7'h6f;
               default: segments[i] <= 7'h00;
            endcase
         end
      end
   end

   // ************************************************
   // Synthesizer and IF/AF outputs
   // ************************************************
   // First synthesizer serial lines
   always_ff @(posedge clk) begin
      if (rst) begin
         synth1 <= '0;
      end else if (wr && portSelectLines == `FPD_WP_SYNTH1A) begin
         synth1.serialData <= portDataIn[`FPD_S1_DATA_BIT];
         synth1.serialClock <= portDataIn[`FPD_S1_CLOCK_BIT];
      end else if (wr && portSelectLines == `FPD_WP_SYNTH1B) begin
         synth1.serialStrobe <= portDataIn[`FPD_S1_STROBE_BIT];
      end
   end

   // Second synthesizer settings
   always_ff @(posedge clk) begin
      if (rst) begin
         synth2 <= {1'b0, `FPD_RST_FREQ};
      end else if (wr && portSelectLines == `FPD_WP_SYNTH2) begin
         synth2.beatOscEnable <= portDataIn[`FPD_BFO_EN_BIT];
         synth2.freqSetting <= portDataIn[6:0];
      end
   end

   // IF/AF data and strobes
   always_ff @(posedge clk) begin
      if (rst) begin
         ifAfData <= `FPD_RST_BYTE;
         ifAfStrobes <= 6'h00;
      end else begin
         ifAfStrobes <= 6'h00;
         if (wr && portSelectLines >= `FPD_WP_IFAF_LO) begin
            ifAfData <= portDataIn;
            ifAfStrobes[portSelectLines[2:0] - 3'h2] <= 1'b1;
         end
      end
   end

   // ************************************************
   // Channel memory
   // ************************************************
   assign memAddr = {rxBus_q[5:0], count_q};

   // Two four-bit halves written together
   always_ff @(posedge clk) begin
      if (wr && portSelectLines == `FPD_WP_MEMORY) begin
         memLo[memAddr] <= portDataIn[3:0];
         memHi[memAddr] <= portDataIn[7:4];
      end
   end

endmodule
